// File: dfmc_pkg.sv
// Constants for the DSP firmware memory control block.
// Assumes a 16-bit register word, a 24-bit host register address and one 200 MHz clock.
// How it works
// - Program word is 40 bits over three consecutive 16-bit register addresses.
// - Coefficient and data words are 24 bits over two consecutive addresses.
// - First DSP: program at 10_0000h, coefficient 18_0000h, X data 19_0000h.
// - Program spaces of DSPs two to four at 20_0000h, 30_0000h, 40_0000h.
// - Shared area reachable at 2A_6000h and 3A_6000h, same storage behind both.
// - Simultaneous shared writes record colliding word offset from area base.
// - Every shared write collision raises a pulse toward the interrupt logic.
// - Host memory access works only while that DSP clock is enabled.
// - DSP clocks derive from the system clock, which host keeps running.
// - Rate code read back per DSP, valid only while clock enabled.
// - Ready flag set once memory accepts access; host waits for it.
// - Each ready flag is offered to the interrupt logic.
// - Each ready flag can be routed to a general-purpose output pin.
// - Retain at 1, the default, keeps memory across clock off and resets.
// - Retain at 0 clears memory when clock gated off and during resets.
// - Power-on reset and sleep entry always clear all firmware memory.
// - Rate code 000 is 6.144 MHz doubling to 49.152, then up to 110; 111 reserved.
package dfmc_pkg;
	localparam int          DFMC_NDSP        = 4;
	localparam int          DFMC_AW          = 24;
	localparam int          DFMC_DW          = 16;
	localparam int          DFMC_PW          = 40;
	localparam int          DFMC_XW          = 24;
	// Stand-in memory depth per space; the address below the depth selects the word
	localparam int          DFMC_DEPTH_LOG   = 4;
	localparam int          DFMC_DEPTH       = 16;
	localparam int          DFMC_SH_LOG      = 12;
	localparam logic [23:0] DFMC_PM_BASE0    = 24'h100000;
	localparam logic [23:0] DFMC_CM_BASE0    = 24'h180000;
	localparam logic [23:0] DFMC_XM_BASE0    = 24'h190000;
	localparam logic [23:0] DFMC_PM_BASE1    = 24'h200000;
	localparam logic [23:0] DFMC_PM_BASE2    = 24'h300000;
	localparam logic [23:0] DFMC_PM_BASE3    = 24'h400000;
	localparam logic [23:0] DFMC_SH_BASE_A   = 24'h2A6000;
	localparam logic [23:0] DFMC_SH_BASE_B   = 24'h3A6000;
	localparam logic [23:0] DFMC_SH_SPAN     = 24'h002000;
	localparam logic [23:0] DFMC_DSP_STRIDE  = 24'h100000;
	localparam logic [23:0] DFMC_CM_OFS      = 24'h080000;
	localparam logic [23:0] DFMC_XM_OFS      = 24'h090000;
	// Local control registers, one group per DSP at index 0..3
	localparam logic [23:0] DFMC_CTRL_BASE   = 24'h001100;
	localparam logic [23:0] DFMC_CLK_BASE    = 24'h001101;
	localparam logic [23:0] DFMC_STS_BASE    = 24'h001104;
	localparam logic [23:0] DFMC_STS3_BASE   = 24'h001106;
	localparam logic [23:0] DFMC_GRP_STRIDE  = 24'h000100;
	localparam logic [23:0] DFMC_COLL_ADDR   = 24'h0013F0;
	localparam logic [23:0] DFMC_GPIO_SEL    = 24'h0013F1;
	localparam int          DFMC_RETAIN_BIT  = 4;
	localparam int          DFMC_CLKEN_BIT   = 2;
	localparam int          DFMC_CORE_BIT    = 0;
	localparam logic        DFMC_RETAIN_RST  = 1'b1;
	localparam logic [2:0]  DFMC_RATE_RST    = 3'h0;
	localparam logic [2:0]  DFMC_RATE_RSVD   = 3'h7;
	// Clears one word per cycle; ready returns when the walk finishes
	localparam logic [3:0]  DFMC_CLR_LAST    = 4'hF;
endpackage : dfmc_pkg

// File: dfmc_top.sv
// DSP firmware memory controller: register port, word packing, shared area, clear control.
// Assumes a host on a plain strobe port and the DSP cores supplying their shared writes.
module dfmc_top
	import dfmc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        por_i,
	input  wire logic        sleep_i,
	input  wire logic [23:0] addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [15:0] rdata_o,
	input  wire logic        dsp2_sh_we_i,
	input  wire logic [3:0]  dsp2_sh_addr_i,
	input  wire logic [23:0] dsp2_sh_data_i,
	input  wire logic        dsp3_sh_we_i,
	input  wire logic [3:0]  dsp3_sh_addr_i,
	input  wire logic [23:0] dsp3_sh_data_i,
	output logic      [3:0]  dsp_clock_en_o,
	output logic      [3:0]  core_run_enable_o,
	output logic      [3:0]  firmware_memory_ready_o,
	output logic             collision_event_o,
	output logic             gpio_status_o
);
	typedef enum logic [1:0] {DFMC_SP_PM = 2'b00, DFMC_SP_CM = 2'b01, DFMC_SP_XM = 2'b10, DFMC_SP_NONE = 2'b11} dfmc_space_e;

	// Which slice of a word a register address is: offset modulo 3 for program words, lowest bit for 2-slice words
	function automatic logic [1:0] dfmc_slice(input logic [23:0] ofs, input logic prog);
		dfmc_slice = prog ? 2'(ofs % 24'd3) : {1'b0, ofs[0]};
	endfunction

	function automatic logic [3:0] dfmc_word(input logic [23:0] ofs, input logic prog);
		dfmc_word = prog ? 4'(ofs / 24'd3) : 4'(ofs >> 1);
	endfunction

	logic [2:0]  rate_sel    [DFMC_NDSP];
	logic [3:0]  clk_en;
	logic [3:0]  retain;
	logic [3:0]  core_en;
	logic [3:0]  ready;
	logic [3:0]  clearing;
	logic [3:0]  clr_idx;
	logic [1:0]  gpio_sel;
	logic [11:0] coll_loc;
	logic [39:0] pm  [DFMC_NDSP][DFMC_DEPTH];
	logic [23:0] cm  [DFMC_NDSP][DFMC_DEPTH];
	logic [23:0] xm  [DFMC_NDSP][DFMC_DEPTH];
	logic [23:0] shm [DFMC_DEPTH];
	logic [39:0] stage;
	logic        por_q1;
	logic        por_q2;
	logic        sleep_q1;
	logic        sleep_q2;
	logic        sleep_d;

	// Address decode: which DSP and space the host address hits
	wire logic [23:0] rel        = addr_i - DFMC_PM_BASE0;
	wire logic [1:0]  hit_dsp    = 2'(rel >> 20);
	wire logic [23:0] dsp_base   = DFMC_PM_BASE0 + 24'(hit_dsp) * DFMC_DSP_STRIDE;
	wire logic        in_dsp     = (addr_i >= DFMC_PM_BASE0) && (addr_i < DFMC_PM_BASE3 + DFMC_DSP_STRIDE);
	wire logic        in_sh_a    = (addr_i >= DFMC_SH_BASE_A) && (addr_i < DFMC_SH_BASE_A + DFMC_SH_SPAN);
	wire logic        in_sh_b    = (addr_i >= DFMC_SH_BASE_B) && (addr_i < DFMC_SH_BASE_B + DFMC_SH_SPAN);
	wire logic        in_sh      = in_sh_a || in_sh_b;
	wire logic [23:0] sh_ofs     = addr_i - (in_sh_a ? DFMC_SH_BASE_A : DFMC_SH_BASE_B);
	wire logic [23:0] pm_ofs     = addr_i - dsp_base;
	wire logic [23:0] cm_ofs     = addr_i - dsp_base - DFMC_CM_OFS;
	wire logic [23:0] xm_ofs     = addr_i - dsp_base - DFMC_XM_OFS;
	wire logic        pm_hit     = in_dsp && (pm_ofs < 24'(3 * DFMC_DEPTH));
	wire logic        cm_hit     = in_dsp && (cm_ofs < 24'(2 * DFMC_DEPTH));
	wire logic        xm_hit     = in_dsp && !in_sh && (xm_ofs < 24'(2 * DFMC_DEPTH));
	wire dfmc_space_e space      = pm_hit ? DFMC_SP_PM : cm_hit ? DFMC_SP_CM : xm_hit ? DFMC_SP_XM : DFMC_SP_NONE;
	wire logic [23:0] mofs       = in_sh ? sh_ofs : (space == DFMC_SP_PM) ? pm_ofs : (space == DFMC_SP_CM) ? cm_ofs : xm_ofs;
	wire logic        is_prog    = (space == DFMC_SP_PM) && !in_sh;
	wire logic [1:0]  slice      = dfmc_slice(mofs, is_prog);
	wire logic [3:0]  widx       = dfmc_word(mofs, is_prog);
	wire logic [11:0] sh_word    = 12'(sh_ofs >> 1);
	wire logic        sh_idx_ok  = sh_word < 12'(DFMC_DEPTH);
	// Memory access only while clock is on and memory ready
	wire logic        sh_ok      = in_sh && sh_idx_ok && ready[1] && ready[2];
	wire logic        mem_ok     = (space != DFMC_SP_NONE) && ready[hit_dsp];
	wire logic        last_slice = is_prog ? (slice == 2'd2) : (slice == 2'd1);
	wire logic        host_sh_wr = wr_i && sh_ok && last_slice;

	// Register decode for the control groups
	wire logic [23:0] grp_rel    = addr_i - DFMC_CTRL_BASE;
	wire logic [1:0]  grp        = 2'(grp_rel >> 8);
	wire logic [23:0] grp_ofs    = 24'(grp) * DFMC_GRP_STRIDE;
	wire logic        grp_range  = (addr_i >= DFMC_CTRL_BASE) && (grp_rel < 24'(DFMC_NDSP) * DFMC_GRP_STRIDE);
	wire logic        sel_ctrl   = grp_range && (addr_i == DFMC_CTRL_BASE + grp_ofs);
	wire logic        sel_clk    = grp_range && (addr_i == DFMC_CLK_BASE + grp_ofs);
	wire logic        sel_sts    = grp_range && (addr_i == DFMC_STS_BASE + grp_ofs);
	wire logic        sel_sts3   = grp_range && (addr_i == DFMC_STS3_BASE + grp_ofs);
	wire logic        sel_coll   = addr_i == DFMC_COLL_ADDR;
	wire logic        sel_gpio   = addr_i == DFMC_GPIO_SEL;

	// Shared-area collision: both DSPs write the same word in one cycle
	wire logic        collide    = dsp2_sh_we_i && dsp3_sh_we_i && (dsp2_sh_addr_i == dsp3_sh_addr_i);

	// Synchronise the asynchronous power-on and sleep indications
	always_ff @(posedge clk_i) begin
		por_q1   <= por_i;
		por_q2   <= por_q1;
		sleep_q1 <= sleep_i;
		sleep_q2 <= sleep_q1;
		sleep_d  <= sleep_q2;
	end

	wire logic        wipe_all   = por_q2 || (sleep_q2 && !sleep_d);

	// Control registers; core enable is forced low whenever the clock gate goes low
	always_ff @(posedge clk_i) begin
		if (reset_i || por_q2) begin
			clk_en   <= 4'h0;
			retain   <= {DFMC_NDSP{DFMC_RETAIN_RST}};
			core_en  <= 4'h0;
			gpio_sel <= 2'h0;
			for (int i = 0; i < DFMC_NDSP; i++) begin
				rate_sel[i] <= DFMC_RATE_RST;
			end
		end else if (wr_i) begin
			if (sel_ctrl) begin
				retain[grp]  <= wdata_i[DFMC_RETAIN_BIT];
				clk_en[grp]  <= wdata_i[DFMC_CLKEN_BIT];
				core_en[grp] <= wdata_i[DFMC_CORE_BIT] && wdata_i[DFMC_CLKEN_BIT];
			end else if (sel_clk) begin
				// Reserved code is ignored so the DSP never runs from an undefined rate
				if (wdata_i[2:0] != DFMC_RATE_RSVD) begin
					rate_sel[grp] <= wdata_i[2:0];
				end
			end else if (sel_gpio) begin
				gpio_sel <= wdata_i[1:0];
			end
		end
	end

	// Memory clear walk and ready flags
	always_ff @(posedge clk_i) begin
		if (wipe_all) begin
			clearing <= 4'hF;
			ready    <= 4'h0;
			clr_idx  <= 4'h0;
		end else begin
			if (|clearing) begin
				clr_idx <= clr_idx + 4'h1;
				if (clr_idx == DFMC_CLR_LAST) begin
					clearing <= 4'h0;
				end
			end
			// One walk at a time; DSPs not being cleared keep tracking their clock meanwhile
			for (int i = 0; i < DFMC_NDSP; i++) begin
				if (!retain[i] && (reset_i || !clk_en[i])) begin
					if (!(|clearing)) begin
						clearing[i] <= 1'b1;
					end
					ready[i] <= 1'b0;
				end else if (!clearing[i]) begin
					ready[i] <= clk_en[i];
				end
			end
		end
	end

	// Staging of partial slices, committed on the last one
	always_ff @(posedge clk_i) begin
		if (wr_i && (mem_ok || sh_ok)) begin
			case (slice)
				2'd0: stage[15:0]  <= wdata_i;
				2'd1: stage[31:16] <= wdata_i;
				default: stage[39:32] <= wdata_i[7:0];
			endcase
		end
	end

	wire logic [39:0] word_in = is_prog ? {wdata_i[7:0], stage[31:0]} : {16'h0, wdata_i[7:0], stage[15:0]};

	always_ff @(posedge clk_i) begin
		for (int i = 0; i < DFMC_NDSP; i++) begin
			if (clearing[i]) begin
				pm[i][clr_idx] <= 40'h0;
				cm[i][clr_idx] <= 24'h0;
				xm[i][clr_idx] <= 24'h0;
			end
		end
		if (clearing[1] || clearing[2]) begin
			shm[clr_idx] <= 24'h0;
		end else if (host_sh_wr) begin
			shm[4'(sh_word)] <= word_in[23:0];
		end else if (dsp3_sh_we_i) begin
			shm[dsp3_sh_addr_i] <= dsp3_sh_data_i; // Later DSP wins on a collision
		end else if (dsp2_sh_we_i) begin
			shm[dsp2_sh_addr_i] <= dsp2_sh_data_i;
		end
		if (wr_i && mem_ok && !in_sh && last_slice && !clearing[hit_dsp]) begin
			case (space)
				DFMC_SP_PM: pm[hit_dsp][widx] <= word_in;
				DFMC_SP_CM: cm[hit_dsp][widx] <= word_in[23:0];
				DFMC_SP_XM: xm[hit_dsp][widx] <= word_in[23:0];
				default: ;
			endcase
		end
	end

	// Collision location and event
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			coll_loc          <= 12'h0;
			collision_event_o <= 1'b0;
		end else begin
			collision_event_o <= collide;
			if (collide) begin
				coll_loc <= 12'(dsp2_sh_addr_i);
			end
		end
	end

	// Read data: selected word, then slice of it
	wire logic [39:0] rd_word = in_sh ? {16'h0, shm[4'(sh_word)]} :
	                            (space == DFMC_SP_PM) ? pm[hit_dsp][widx] :
	                            (space == DFMC_SP_CM) ? {16'h0, cm[hit_dsp][widx]} : {16'h0, xm[hit_dsp][widx]};
	wire logic [15:0] rd_mem  = (slice == 2'd0) ? rd_word[15:0] :
	                            (slice == 2'd1) ? (is_prog ? rd_word[31:16] : {8'h0, rd_word[23:16]}) :
	                            {8'h0, rd_word[39:32]};
	wire logic [2:0]  rate_rb = clk_en[grp] ? rate_sel[grp] : 3'h0;
	logic [15:0] rd_next;

	always_comb begin
		rd_next = 16'h0;
		if (sel_ctrl) begin
			rd_next = 16'({retain[grp], 1'b0, clk_en[grp], 1'b0, core_en[grp]});
		end else if (sel_clk) begin
			rd_next = {13'h0, rate_sel[grp]};
		end else if (sel_sts) begin
			rd_next = {15'h0, ready[grp]};
		end else if (sel_sts3) begin
			rd_next = {12'h0, rate_rb, clk_en[grp]};
		end else if (sel_coll) begin
			rd_next = {4'h0, coll_loc};
		end else if (sel_gpio) begin
			rd_next = {14'h0, gpio_sel};
		end else if (sh_ok || mem_ok) begin
			rd_next = rd_mem;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rdata_o <= 16'h0;
		end else if (rd_i) begin
			rdata_o <= rd_next;
		end
	end

	assign dsp_clock_en_o          = clk_en;
	assign core_run_enable_o       = core_en;
	assign firmware_memory_ready_o = ready;
	assign gpio_status_o           = ready[gpio_sel];
endmodule // dfmc_top

// File: dfmc_top_asserts.sv
// Checker for dfmc_top port timing and status relations.
// Assumes it is bound to dfmc_top and sees only its ports.
module dfmc_asserts
	import dfmc_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic        por_i,
	input wire logic [23:0] addr_i,
	input wire logic        rd_i,
	input wire logic [15:0] rdata_o,
	input wire logic        dsp2_sh_we_i,
	input wire logic [3:0]  dsp2_sh_addr_i,
	input wire logic        dsp3_sh_we_i,
	input wire logic [3:0]  dsp3_sh_addr_i,
	input wire logic [3:0]  dsp_clock_en_o,
	input wire logic [3:0]  firmware_memory_ready_o,
	input wire logic        collision_event_o,
	input wire logic        gpio_status_o
);
	logic [3:0] por_sh;
	wire        coll   = dsp2_sh_we_i && dsp3_sh_we_i && (dsp2_sh_addr_i == dsp3_sh_addr_i);
	// Power-on clear lags its pin through the synchroniser, so keep quiet a while longer
	wire        quiet  = reset_i || por_i || (|por_sh);
	always_ff @(posedge clk_i) por_sh <= {por_sh[2:0], por_i};
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (quiet);
	property p_coll_set; coll |=> collision_event_o; endproperty
	a_coll_set: assert property (p_coll_set) else $error("collision not flagged");
	property p_coll_cause; collision_event_o |-> $past(coll); endproperty
	a_coll_cause: assert property (p_coll_cause) else $error("stray collision event");
	property p_rd_hold; !rd_i |=> $stable(rdata_o); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
	property p_refuse; rd_i && addr_i[23:20] == 4'h1 && !firmware_memory_ready_o[0] |=> rdata_o == 16'h0000; endproperty
	a_refuse: assert property (p_refuse) else $error("memory read while not ready");
	property p_ready_clk; (firmware_memory_ready_o & ~$past(dsp_clock_en_o)) == 4'h0; endproperty
	a_ready_clk: assert property (p_ready_clk) else $error("ready without clock");
	property p_ready_lag; $rose(dsp_clock_en_o[0]) |-> ##[1:24] firmware_memory_ready_o[0]; endproperty
	a_ready_lag: assert property (p_ready_lag) else $error("ready late");
	property p_gpio; gpio_status_o |-> |firmware_memory_ready_o; endproperty
	a_gpio: assert property (p_gpio) else $error("gpio status without ready");
	property p_por; disable iff (reset_i) $rose(por_i) |-> ##[1:6] firmware_memory_ready_o == 4'h0; endproperty
	a_por: assert property (p_por) else $error("power-on did not clear");
	c_coll: cover property (coll);
	c_rdy3: cover property ($rose(firmware_memory_ready_o[3]));
	c_loc: cover property (rd_i && addr_i == DFMC_COLL_ADDR);
endmodule // dfmc_asserts
bind dfmc_top dfmc_asserts dfmc_asserts_inst (.clk_i, .reset_i, .por_i, .addr_i, .rd_i, .rdata_o,
	.dsp2_sh_we_i, .dsp2_sh_addr_i, .dsp3_sh_we_i, .dsp3_sh_addr_i, .dsp_clock_en_o,
	.firmware_memory_ready_o, .collision_event_o, .gpio_status_o);

// File: dfmc_host.sv
// Host model on the register port: strobe cycles and ready polling.
// Assumes a running clock and read data in the cycle after the strobe.
module dfmc_host
	import dfmc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic [15:0] rdata_i,
	output logic      [23:0] addr_o,
	output logic      [15:0] wdata_o,
	output logic             wr_o,
	output logic             rd_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		addr_o = 24'h000000;
		wdata_o = 16'h0000;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// Released lines are inverted so a stale value never looks valid
	task wr_reg(input logic [23:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask
	task rd_reg(input logic [23:0] a, output logic [15:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		// Data stands for the whole following cycle; take it at that cycle's closing edge
		@(posedge clk_i);
		d = rdata_i;
	endtask
	// Memory is not touched before the ready bit reads back set or 40 polling reads have passed
	task wait_rdy(input logic [23:0] a);
		logic [15:0] s;
		s = 16'h0000;
		for (int i = 0; i < 40 && s[0] !== 1'b1; i++) rd_reg(a, s);
	endtask
endmodule // dfmc_host

// File: tb_dfmc_top.sv
// Bench for dfmc_top: firmware loads, retention, shared area and status checks.
// Assumes dfmc_host on the register port; shared DSP writes come from here.
module tb_dfmc_top
	import dfmc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_i = 1'b0, reset_i = 1'b1, por_i = 1'b1, sleep_i = 1'b0;
	logic [23:0] addr, d2 = 24'h0, d3 = 24'h0, b;
	logic [15:0] wdata, rdata, v;
	logic        wr, rd, we2 = 1'b0, we3 = 1'b0, coll, gpio;
	logic [3:0]  a2 = 4'h0, a3 = 4'h0, clk_en, core, rdy;
	logic [15:0] pw [5] = '{16'h1234, 16'h5678, 16'h77AB, 16'h1111, 16'h2222};
	int          n_fail = 0, n_compared = 0, cyc = 0;
	always #2.5 clk_i = ~clk_i;
	dfmc_host dfmc_host_inst (.clk_i, .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
	dfmc_top dfmc_top_inst (.clk_i, .reset_i, .por_i, .sleep_i, .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.rd_i(rd), .rdata_o(rdata), .dsp2_sh_we_i(we2), .dsp2_sh_addr_i(a2), .dsp2_sh_data_i(d2),
		.dsp3_sh_we_i(we3), .dsp3_sh_addr_i(a3), .dsp3_sh_data_i(d3), .dsp_clock_en_o(clk_en),
		.core_run_enable_o(core), .firmware_memory_ready_o(rdy), .collision_event_o(coll), .gpio_status_o(gpio));
	task end_sim;
		$display("Compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task chk16(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("Error at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task chk1(input logic g, input logic e);
		chk16({15'h0, g}, {15'h0, e});
	endtask
	task rd_chk(input logic [23:0] a, input logic [15:0] e);
		dfmc_host_inst.rd_reg(a, v);
		chk16(v, e);
	endtask
	function automatic logic [23:0] grp(int n, logic [23:0] base);
		return base + 24'(n) * DFMC_GRP_STRIDE;
	endfunction
	task en(int n, logic [15:0] c);
		dfmc_host_inst.wr_reg(grp(n, DFMC_CTRL_BASE), c);
		dfmc_host_inst.wait_rdy(grp(n, DFMC_STS_BASE));
	endtask
	// A hang costs a mismatch rather than an endless run
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			end_sim();
		end
	end
	initial begin
		// Power-on clear under reset, so every memory starts from a known zero
		repeat (4) @(posedge clk_i);
		por_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		reset_i <= 1'b0;
		rd_chk(grp(0, DFMC_CTRL_BASE), 16'h0010);
		for (int i = 0; i < 3; i++) dfmc_host_inst.wr_reg(DFMC_PM_BASE0 + 24'(i), 16'hAAAA);
		rd_chk(DFMC_PM_BASE0 + 24'h2, 16'h0000);
		en(0, 16'h0015);
		#1 chk16({8'h0, clk_en, core}, 16'h0011);
		rd_chk(DFMC_PM_BASE0, 16'h0000);
		for (int i = 0; i < 5; i++) dfmc_host_inst.wr_reg(DFMC_PM_BASE0 + 24'(i), pw[i]);
		for (int i = 0; i < 5; i++) rd_chk(DFMC_PM_BASE0 + 24'(i), i == 2 ? 16'h00AB : i < 3 ? pw[i] : 16'h0);
		for (int i = 0; i < 2; i++) begin
			b = i == 0 ? DFMC_CM_BASE0 : DFMC_XM_BASE0 + 24'h2;
			dfmc_host_inst.wr_reg(b, 16'hBEEF);
			dfmc_host_inst.wr_reg(b + 24'h1, 16'h0042);
			rd_chk(b, 16'hBEEF);
			rd_chk(b + 24'h1, 16'h0042);
		end
		for (int c = 0; c < 7; c++) begin
			dfmc_host_inst.wr_reg(grp(0, DFMC_CLK_BASE), 16'(c));
			rd_chk(grp(0, DFMC_STS3_BASE), {12'h0, 3'(c), 1'b1});
		end
		dfmc_host_inst.wr_reg(grp(0, DFMC_CLK_BASE), 16'h0007);
		rd_chk(grp(0, DFMC_STS3_BASE), 16'h000D);
		dfmc_host_inst.wr_reg(grp(0, DFMC_CTRL_BASE), 16'h0010);
		rd_chk(grp(0, DFMC_STS3_BASE), 16'h0000);
		#1 chk16({8'h0, clk_en, core}, 16'h0000);
		reset_i <= 1'b1;
		@(posedge clk_i);
		reset_i <= 1'b0;
		en(0, 16'h0015);
		rd_chk(DFMC_PM_BASE0, 16'h1234);
		dfmc_host_inst.wr_reg(grp(0, DFMC_CTRL_BASE), 16'h0005);
		dfmc_host_inst.wr_reg(grp(0, DFMC_CTRL_BASE), 16'h0000);
		en(0, 16'h0005);
		rd_chk(DFMC_PM_BASE0, 16'h0000);
		for (int n = 1; n < 4; n++) begin
			b = DFMC_PM_BASE0 + 24'(n) * DFMC_DSP_STRIDE;
			en(n, 16'h0015);
			for (int s = 0; s < 3; s++) dfmc_host_inst.wr_reg(b + 24'(s), 16'(n));
			rd_chk(b, 16'(n));
		end
		dfmc_host_inst.wr_reg(DFMC_SH_BASE_A, 16'hC0DE);
		dfmc_host_inst.wr_reg(DFMC_SH_BASE_A + 24'h1, 16'h0099);
		rd_chk(DFMC_SH_BASE_B, 16'hC0DE);
		rd_chk(DFMC_SH_BASE_B + 24'h1, 16'h0099);
		@(posedge clk_i);
		{we2, we3, a2, a3, d2, d3} <= {2'b11, 8'h55, 24'h111111, 24'h222222};
		@(posedge clk_i);
		{we2, we3} <= 2'b00;
		#1 chk1(coll, 1'b1);
		@(posedge clk_i);
		#1 chk1(coll, 1'b0);
		rd_chk(DFMC_COLL_ADDR, 16'h0005);
		rd_chk(DFMC_SH_BASE_B + 24'hA, 16'h2222);
		rd_chk(DFMC_SH_BASE_A + 24'hB, 16'h0022);
		dfmc_host_inst.wr_reg(DFMC_GPIO_SEL, 16'h0001);
		#1 chk1(gpio, 1'b1);
		dfmc_host_inst.wr_reg(grp(1, DFMC_CTRL_BASE), 16'h0010);
		rd_chk(grp(1, DFMC_STS_BASE), 16'h0000);
		#1 chk1(gpio, 1'b0);
		sleep_i <= 1'b1;
		repeat (20) @(posedge clk_i);
		sleep_i <= 1'b0;
		en(2, 16'h0015);
		rd_chk(DFMC_PM_BASE2, 16'h0000);
		por_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		por_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		en(3, 16'h0015);
		rd_chk(DFMC_PM_BASE3, 16'h0000);
		end_sim();
	end
endmodule // tb_dfmc_top
